// >>> core/chirp_param_dither_sequencer.sv
`timescale 1ns/1ps
`include "dither_regs.svh"
module chirp_param_dither_sequencer (
   input  wire logic                      CLOCK_I,                 // 50 MHz chirp clock
   input  wire logic                      RST_B_I,                 // async reset, active low
   input  wire logic                      CHIRP_START_I,           // one pulse per chirp
   input  wire logic                      FRAME_END_I,             // end of frame pulse
   input  wire logic                      SUBFRAME_END_I,          // end of sub-frame pulse
   input  wire logic                      BURST_END_I,             // end of burst pulse
   input  wire logic [1:0]                RESET_MODE_I,            // restart boundary select
   input  wire logic [2:0]                OUTPUT_MODE_SELECT_I,    // 4 legacy, 5 sub-frame
   input  wire logic [1:0]                SUBFRAME_SEL_I,          // current sub-frame 0..3
   input  wire logic [31:0]               BASE_VALUE_I,            // profile base value
   input  wire logic [14:0]               DELTA_STEP_PERIOD_I,     // N, 0..16384
   input  wire logic [15:0]               DELTA_RESTART_PERIOD_I,  // M, 0..32768
   input  wire dither_pkg::delta_array_t  SUBFRAME_DELTA_VALUE_I,  // deltas, sub-frame 0..3
   input  wire logic [14:0]               TABLE_STEP_PERIOD_I,     // K, 0..16384
   input  wire logic [15:0]               TABLE_RESTART_PERIOD_I,  // J, 0..32768
   input  wire logic [9:0]                TABLE_START_OFFSET_I,    // byte offset in table
   input  wire logic [8:0]                PATTERN_COUNT_I,         // unique entries, >= 1
   input  wire logic [1:0]                TABLE_ENTRY_SIZE_I,      // 0 word, 1 half, 2 byte
   input  wire logic                      PARAM_IS_SIZED_I,        // parameter honours size
   input  wire logic [7:0]                SUBFRAME_TABLE_SHIFT_I,  // mode 5 index shift
   input  wire logic [15:0]               LOOP_COUNT_I,            // chirps per frame, mode 4/5
   input  wire logic [15:0]               CHIRP_COUNT_I,           // chirps per frame, others
   input  wire logic                      TABLE_WR_EN_I,           // table word write strobe
   input  wire logic [7:0]                TABLE_WR_ADDR_I,         // table word address
   input  wire logic [31:0]               TABLE_WR_DATA_I,         // table word data
   output logic [31:0]                    PARAM_VALUE_O,           // dithered parameter
   output logic                           PARAM_VALID_O,           // value strobe
   output logic                           FRAME_DONE_O             // last chirp of frame
);
   // *************************************************
   // state and table memory
   // *************************************************
   dither_pkg::seq_st_t st;
   dither_pkg::seq_st_t nxt;
   table_mem_if         mif ();

   logic        accept;
   logic        boundary;
   logic        adv_mode;
   logic [31:0] delta_sel;
   logic [1:0]  size_eff;
   logic [13:0] ent_num;
   logic [15:0] byte_addr;
   logic [15:0] frame_total;
   logic [31:0] shifted;
   logic [31:0] entry_val;

   dither_table_mem u_mem (
      .clk_i   (CLOCK_I),
      .rst_b_i (RST_B_I),
      .mif     (mif)
   );

   // *************************************************
   // per-chirp selections
   // *************************************************
   always_comb begin
      accept   = (st.state == dither_pkg::SEQ_IDLE) && CHIRP_START_I;
      adv_mode = (OUTPUT_MODE_SELECT_I == `MODE_LEGACY_FRAME) ||
                 (OUTPUT_MODE_SELECT_I == `MODE_SUBFRAME);
      // frame end closes every sub-frame and burst, so it always restarts
      boundary = FRAME_END_I ||
                 (SUBFRAME_END_I && (RESET_MODE_I != `RESET_AT_FRAME)) ||
                 (BURST_END_I && (RESET_MODE_I == `RESET_AT_BURST));
      // only sub-frame mode picks a per-sub-frame delta
      delta_sel = (OUTPUT_MODE_SELECT_I == `MODE_SUBFRAME) ?
                  SUBFRAME_DELTA_VALUE_I[SUBFRAME_SEL_I] : SUBFRAME_DELTA_VALUE_I[0];
      size_eff  = (PARAM_IS_SIZED_I && (TABLE_ENTRY_SIZE_I != 2'h3)) ?
                  TABLE_ENTRY_SIZE_I : `ENTRY_SIZE_WORD;
      ent_num   = 14'(st.idx);
      if (OUTPUT_MODE_SELECT_I == `MODE_SUBFRAME) begin
         ent_num = ent_num + 14'(SUBFRAME_TABLE_SHIFT_I) * 14'(SUBFRAME_SEL_I);
      end
      case (size_eff)
         `ENTRY_SIZE_HALF: byte_addr = 16'(TABLE_START_OFFSET_I) + (16'(ent_num) << 1);
         `ENTRY_SIZE_BYTE: byte_addr = 16'(TABLE_START_OFFSET_I) + 16'(ent_num);
         default:          byte_addr = 16'(TABLE_START_OFFSET_I) + (16'(ent_num) << 2);
      endcase
      frame_total = adv_mode ? LOOP_COUNT_I : CHIRP_COUNT_I;
   end

   // *************************************************
   // table port and entry extraction
   // *************************************************
   assign mif.wr_en   = TABLE_WR_EN_I;
   assign mif.wr_addr = TABLE_WR_ADDR_I;
   assign mif.wr_data = TABLE_WR_DATA_I;
   assign mif.rd_en   = accept;
   assign mif.rd_addr = byte_addr[`WORD_ADDR_MSB:`WORD_ADDR_LSB];

   // narrow entries are sign extended from their byte lane
   always_comb begin
      shifted = mif.rd_data >> {st.lane, 3'h0};
      case (st.size_used)
         `ENTRY_SIZE_HALF: entry_val = {{16{shifted[15]}}, shifted[15:0]};
         `ENTRY_SIZE_BYTE: entry_val = {{24{shifted[7]}}, shifted[7:0]};
         default:          entry_val = mif.rd_data;
      endcase
   end

   // *************************************************
   // sequencer next state
   // *************************************************
   always_comb begin
      nxt            = st;
      nxt.valid      = 1'b0;
      nxt.frame_done = 1'b0;
      case (st.state)
         dither_pkg::SEQ_IDLE: begin
            if (accept) begin
               nxt.state     = dither_pkg::SEQ_FETCH;
               nxt.base_used = BASE_VALUE_I;
               nxt.acc_used  = st.acc;
               nxt.lane      = byte_addr[1:0];
               nxt.size_used = size_eff;
               // delta accumulation after every N chirps
               if ((DELTA_STEP_PERIOD_I != 15'h0000) &&
                   (DELTA_RESTART_PERIOD_I != 16'h0001)) begin
                  if (st.n_cnt + 16'h0001 == {1'b0, DELTA_STEP_PERIOD_I}) begin
                     nxt.acc   = st.acc + delta_sel;
                     nxt.n_cnt = `COUNT_RESET;
                  end else begin
                     nxt.n_cnt = st.n_cnt + 16'h0001;
                  end
               end
               if (DELTA_RESTART_PERIOD_I > 16'h0001) begin
                  if (st.m_cnt + 16'h0001 == DELTA_RESTART_PERIOD_I) begin
                     nxt.acc   = `VALUE_RESET;
                     nxt.n_cnt = `COUNT_RESET;
                     nxt.m_cnt = `COUNT_RESET;
                  end else begin
                     nxt.m_cnt = st.m_cnt + 16'h0001;
                  end
               end
               // table index walk after every K chirps, wrapping at the pattern count
               if ((TABLE_STEP_PERIOD_I != 15'h0000) &&
                   (TABLE_RESTART_PERIOD_I != 16'h0001)) begin
                  if (st.k_cnt + 16'h0001 == {1'b0, TABLE_STEP_PERIOD_I}) begin
                     nxt.k_cnt = `COUNT_RESET;
                     nxt.idx   = (9'(st.idx) + 9'h001 >= PATTERN_COUNT_I) ?
                                 `INDEX_RESET : st.idx + 8'h01;
                  end else begin
                     nxt.k_cnt = st.k_cnt + 16'h0001;
                  end
               end else begin
                  nxt.idx = `INDEX_RESET;
               end
               if (TABLE_RESTART_PERIOD_I > 16'h0001) begin
                  if (st.j_cnt + 16'h0001 == TABLE_RESTART_PERIOD_I) begin
                     nxt.idx   = `INDEX_RESET;
                     nxt.k_cnt = `COUNT_RESET;
                     nxt.j_cnt = `COUNT_RESET;
                  end else begin
                     nxt.j_cnt = st.j_cnt + 16'h0001;
                  end
               end
               // chirps per frame counting
               if (st.frame_cnt + 16'h0001 >= frame_total) begin
                  nxt.frame_cnt  = `COUNT_RESET;
                  nxt.frame_done = 1'b1;
               end else begin
                  nxt.frame_cnt = st.frame_cnt + 16'h0001;
               end
            end
         end
         dither_pkg::SEQ_FETCH: begin
            nxt.value = st.base_used + st.acc_used + entry_val;
            nxt.valid = 1'b1;
            nxt.state = dither_pkg::SEQ_IDLE;
         end
         default: begin
            nxt.state = dither_pkg::SEQ_IDLE;
         end
      endcase
      // a boundary wins over the chirp's own step in the same cycle
      if (boundary) begin
         nxt.acc   = `VALUE_RESET;
         nxt.idx   = `INDEX_RESET;
         nxt.n_cnt = `COUNT_RESET;
         nxt.m_cnt = `COUNT_RESET;
         nxt.k_cnt = `COUNT_RESET;
         nxt.j_cnt = `COUNT_RESET;
      end
      if (FRAME_END_I || SUBFRAME_END_I) begin
         nxt.frame_cnt = `COUNT_RESET;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st <= '0;
      end else begin
         st <= nxt;
      end
   end

   assign PARAM_VALUE_O = st.value;
   assign PARAM_VALID_O = st.valid;
   assign FRAME_DONE_O  = st.frame_done;

   // *************************************************
   // assertions and covers
   // *************************************************
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);

   result_latency_a: assert property (accept |-> ##2 PARAM_VALID_O)
      else $error("result strobe not two cycles after chirp");
   value_sum_a: assert property (PARAM_VALID_O |->
      PARAM_VALUE_O == $past(BASE_VALUE_I, 2) + $past(st.acc, 2) + $past(entry_val))
      else $error("value is not base plus delta plus entry");
   // a restart period of two or more may still return the delta to zero
   delta_off_a: assert property ((DELTA_STEP_PERIOD_I == 15'h0000) && !boundary
      |=> (st.acc == $past(st.acc)) || (st.acc == 32'h00000000))
      else $error("delta moved with step period zero");
   restart_one_a: assert property ((DELTA_RESTART_PERIOD_I == 16'h0001) && !boundary
      |=> st.acc == $past(st.acc))
      else $error("delta moved with restart period one");
   boundary_clear_a: assert property (boundary |=> (st.acc == 32'h00000000) &&
      (st.idx == 8'h00))
      else $error("boundary did not restart sequences");
   legacy_delta_a: assert property (accept && (OUTPUT_MODE_SELECT_I != `MODE_SUBFRAME)
      && !boundary && (DELTA_RESTART_PERIOD_I == 16'h0000) && (DELTA_STEP_PERIOD_I != 15'h0000)
      && (st.n_cnt + 16'h0001 == {1'b0, DELTA_STEP_PERIOD_I})
      |=> st.acc == $past(st.acc) + $past(SUBFRAME_DELTA_VALUE_I[0]))
      else $error("legacy mode did not add the sub-frame 0 delta");
   table_pinned_a: assert property (accept && ((TABLE_STEP_PERIOD_I == 15'h0000) ||
      (TABLE_RESTART_PERIOD_I == 16'h0001)) |=> st.idx == 8'h00)
      else $error("table index left entry 0 while pinned");
   first_entry_a: assert property (FRAME_END_I |=> st.idx == 8'h00)
      else $error("frame did not start at entry 0");
   frame_done_a: assert property (FRAME_DONE_O |->
      $past(st.frame_cnt) + 16'h0001 >= $past(frame_total))
      else $error("frame done before chirp total");

   cover_delta_step: cover property (accept && (st.n_cnt + 16'h0001 ==
      {1'b0, DELTA_STEP_PERIOD_I}) && (DELTA_STEP_PERIOD_I != 15'h0000));
   cover_table_wrap: cover property (accept && (st.idx != 8'h00) ##1 st.idx == 8'h00);
   cover_frame_done: cover property (FRAME_DONE_O);
   cover_subframe_mode: cover property (accept && (OUTPUT_MODE_SELECT_I == `MODE_SUBFRAME)
      && (SUBFRAME_SEL_I == 2'h3));
endmodule

// >>> core/dither_regs.svh
`ifndef DITHER_REGS_SVH
`define DITHER_REGS_SVH

// *************************************************
// mode and option codes
// *************************************************
`define MODE_LEGACY_FRAME   3'h4
`define MODE_SUBFRAME       3'h5
`define RESET_AT_FRAME      2'h0
`define RESET_AT_SUBFRAME   2'h1
`define RESET_AT_BURST      2'h2
`define ENTRY_SIZE_WORD     2'h0
`define ENTRY_SIZE_HALF     2'h1
`define ENTRY_SIZE_BYTE     2'h2

// *************************************************
// field positions, reset values, timing
// *************************************************
`define WORD_ADDR_MSB       9
`define WORD_ADDR_LSB       2
`define COUNT_RESET         16'h0000
`define VALUE_RESET         32'h00000000
`define INDEX_RESET         8'h00
`define RESULT_LATENCY      2

`endif

// >>> core/dither_pkg.sv
package dither_pkg;

   // *************************************************
   // types
   // *************************************************
   typedef logic [3:0][31:0] delta_array_t;

   typedef enum logic [0:0] {
      SEQ_IDLE  = 1'h0,
      SEQ_FETCH = 1'h1
   } seq_state_t;

   typedef struct packed {
      seq_state_t  state;
      logic [15:0] n_cnt;
      logic [15:0] m_cnt;
      logic [15:0] k_cnt;
      logic [15:0] j_cnt;
      logic [31:0] acc;
      logic [31:0] acc_used;
      logic [31:0] base_used;
      logic [7:0]  idx;
      logic [1:0]  lane;
      logic [1:0]  size_used;
      logic [15:0] frame_cnt;
      logic [31:0] value;
      logic        valid;
      logic        frame_done;
   } seq_st_t;

   typedef struct packed {
      logic [255:0][31:0] words;
      logic [31:0]        rd_data;
   } mem_st_t;

endpackage

// >>> core/table_mem_if.sv
`timescale 1ns/1ps
interface table_mem_if;
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic        rd_en;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;

   modport user (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// >>> core/dither_table_mem.sv
`timescale 1ns/1ps
module dither_table_mem (
   input  wire logic  clk_i,    // chirp clock
   input  wire logic  rst_b_i,  // async reset, active low
   table_mem_if.mem   mif       // write and registered read port
);
   dither_pkg::mem_st_t st;
   dither_pkg::mem_st_t nxt;

   // write first, read data registered on the enable
   always_comb begin
      nxt = st;
      if (mif.wr_en) begin
         nxt.words[mif.wr_addr] = mif.wr_data;
      end
      if (mif.rd_en) begin
         nxt.rd_data = nxt.words[mif.rd_addr];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st <= '0;
      end else begin
         st <= nxt;
      end
   end

   assign mif.rd_data = st.rd_data;
endmodule

// >>> tb/chirp_timer_model.sv
`timescale 1ns/1ps
// ****************************************
// chirp timing engine at the far side
// ****************************************
module chirp_timer_model (
   input  wire logic        clk_i,         // chirp clock
   input  wire logic        rst_b_i,       // reset, active low
   input  wire logic        go_i,          // start a run of chirps
   input  wire logic [7:0]  count_i,       // chirps in the run
   input  wire logic [31:0] value_i,       // dithered value
   input  wire logic        valid_i,       // value strobe
   input  wire logic        done_i,        // frame done pulse
   output logic             chirp_start_o, // chirp pulse
   output logic             busy_o,        // run in progress
   output logic [31:0]      last_value_o,  // last value taken
   output logic [7:0]       done_count_o   // frame done pulses seen
);
   logic [7:0] left_reg;
   logic [2:0] gap_reg;

   // busy until the last result of the run has been taken
   assign busy_o = (left_reg != 8'h00) || (gap_reg != 3'h0);

   // pulses five cycles apart, so the result always lands before the next one
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         left_reg <= 8'h00;
         gap_reg <= 3'h0;
         chirp_start_o <= 1'b0;
         last_value_o <= 32'h00000000;
         done_count_o <= 8'h00;
      end else begin
         chirp_start_o <= 1'b0;
         if (valid_i) begin
            last_value_o <= value_i;
         end
         if (done_i) begin
            done_count_o <= done_count_o + 8'h01;
         end
         if (go_i && !busy_o) begin
            left_reg <= count_i;
         end else if (gap_reg != 3'h0) begin
            gap_reg <= gap_reg - 3'h1;
         end else if (left_reg != 8'h00) begin
            chirp_start_o <= 1'b1;
            left_reg <= left_reg - 8'h01;
            gap_reg <= 3'h4;
         end
      end
   end
endmodule

// >>> tb/test_chirp_param_dither_sequencer.sv
`timescale 1ns/1ps
module test_chirp_param_dither_sequencer;
   typedef struct packed {
      logic [14:0] n;
      logic [15:0] m;
      logic [14:0] k;
      logic [15:0] j;
      logic [7:0]  c;
      logic [31:0] e;
   } row_t;

   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic                     clk = 1'b0;
   logic                     rst_b = 1'b0;
   logic                     chirp, valid, fdone, busy;
   logic                     frame_end = 1'b0, sub_end = 1'b0, burst_end = 1'b0;
   logic [1:0]               rmode = 2'h0, sf_sel = 2'h0, esize = 2'h0;
   logic [2:0]               omode = 3'h4;
   logic [14:0]              n_per = 15'h0000, k_per = 15'h0000;
   logic [15:0]              m_per = 16'h0000, j_per = 16'h0000;
   logic [15:0]              loops = 16'h0064, chirps = 16'h0064;
   logic [9:0]               offs = 10'h000;
   logic [8:0]               pats = 9'h004;
   logic                     sized = 1'b1, wr_en = 1'b0, go = 1'b0;
   logic [7:0]               shift = 8'h01, wr_addr = 8'h00, count = 8'h00, dones;
   logic [31:0]              wr_data = 32'h00000000, value, last, d;
   dither_pkg::delta_array_t deltas = {32'h400, 32'h300, 32'h200, 32'h100};
   int                       mismatches = 0, compares = 0, cycles = 0;
   // base 1000, delta 100, table words 10 20 30 40, four patterns
   row_t rows [6] = '{'{15'h0, 16'h0, 15'h0, 16'h0, 8'h05, 32'h1010},
                      '{15'h1, 16'h0, 15'h1, 16'h0, 8'h03, 32'h1230},
                      '{15'h3, 16'h0, 15'h0, 16'h0, 8'h04, 32'h1110},
                      '{15'h2, 16'h1, 15'h1, 16'h1, 8'h05, 32'h1010},
                      '{15'h2, 16'h4, 15'h2, 16'h4, 8'h08, 32'h1120},
                      '{15'h1, 16'h0, 15'h1, 16'h0, 8'h06, 32'h1520}};
   logic [1:0]  b_mode [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
   logic        b_burst [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   logic [31:0] b_exp [4] = '{32'h1230, 32'h1010, 32'h1230, 32'h1010};

   chirp_param_dither_sequencer u_dut (
      .CLOCK_I(clk), .RST_B_I(rst_b), .CHIRP_START_I(chirp), .FRAME_END_I(frame_end),
      .SUBFRAME_END_I(sub_end), .BURST_END_I(burst_end), .RESET_MODE_I(rmode),
      .OUTPUT_MODE_SELECT_I(omode), .SUBFRAME_SEL_I(sf_sel), .BASE_VALUE_I(32'h00001000),
      .DELTA_STEP_PERIOD_I(n_per), .DELTA_RESTART_PERIOD_I(m_per),
      .SUBFRAME_DELTA_VALUE_I(deltas), .TABLE_STEP_PERIOD_I(k_per),
      .TABLE_RESTART_PERIOD_I(j_per), .TABLE_START_OFFSET_I(offs), .PATTERN_COUNT_I(pats),
      .TABLE_ENTRY_SIZE_I(esize), .PARAM_IS_SIZED_I(sized), .SUBFRAME_TABLE_SHIFT_I(shift),
      .LOOP_COUNT_I(loops), .CHIRP_COUNT_I(chirps), .TABLE_WR_EN_I(wr_en),
      .TABLE_WR_ADDR_I(wr_addr), .TABLE_WR_DATA_I(wr_data), .PARAM_VALUE_O(value),
      .PARAM_VALID_O(valid), .FRAME_DONE_O(fdone));

   chirp_timer_model u_timer (
      .clk_i(clk), .rst_b_i(rst_b), .go_i(go), .count_i(count), .value_i(value),
      .valid_i(valid), .done_i(fdone), .chirp_start_o(chirp), .busy_o(busy),
      .last_value_o(last), .done_count_o(dones));

   // ****************************************
   // clock, time limit, shared tasks
   // ****************************************
   always #10 clk = ~clk;

   // a hang counts as a mismatch and closes the run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic put(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= v;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // optional frame end, then a run of chirps until the last result is in
   task automatic burst(input logic restart, input logic [7:0] n);
      int t;
      t = 0;
      if (restart) begin
         @(posedge clk);
         frame_end <= 1'b1;
      end
      @(posedge clk);
      frame_end <= 1'b0;
      count <= n;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
      while (busy && t < 200) begin
         @(posedge clk);
         t++;
      end
      // a run that never finishes counts as a mismatch
      check({31'h0, busy}, 32'h0);
   endtask

   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      check(value, 32'h0);
      check({30'h0, valid, fdone}, 32'h0);
      rst_b <= 1'b1;
      $display("test reset done");
      for (int i = 0; i < 4; i++) put(i[7:0], 32'(16 * (i + 1)));
      put(8'h10, 32'hFFFE0005);
      put(8'h11, 32'h00000007);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         n_per <= rows[i].n;
         m_per <= rows[i].m;
         k_per <= rows[i].k;
         j_per <= rows[i].j;
         burst(1'b1, rows[i].c);
         check(last, rows[i].e);
      end
      $display("test rows done");
      @(posedge clk);
      omode <= 3'h5;
      sf_sel <= 2'h2;
      n_per <= 15'h1;
      m_per <= 16'h0;
      k_per <= 15'h0;
      j_per <= 16'h0;
      burst(1'b1, 8'h02);
      check(last, 32'h1330);
      omode <= 3'h4;
      burst(1'b1, 8'h02);
      check(last, 32'h1110);
      $display("test sub-frame done");
      sf_sel <= 2'h0;
      n_per <= 15'h0;
      k_per <= 15'h1;
      offs <= 10'h040;
      esize <= 2'h1;
      burst(1'b1, 8'h02);
      check(last, 32'h0FFE);
      esize <= 2'h2;
      burst(1'b1, 8'h04);
      check(last, 32'h00000FFF);
      sized <= 1'b0;
      burst(1'b1, 8'h02);
      check(last, 32'h1007);
      $display("test entry size done");
      offs <= 10'h000;
      esize <= 2'h0;
      sized <= 1'b1;
      loops <= 16'h0003;
      chirps <= 16'h0007;
      d = {24'h0, dones};
      burst(1'b1, 8'h03);
      check({24'h0, dones} - d, 32'h1);
      omode <= 3'h0;
      d = {24'h0, dones};
      burst(1'b1, 8'h03);
      check({24'h0, dones} - d, 32'h0);
      $display("test frame length done");
      omode <= 3'h4;
      n_per <= 15'h1;
      for (int i = 0; i < 4; i++) begin
         rmode <= b_mode[i];
         burst(1'b1, 8'h02);
         @(posedge clk);
         sub_end <= !b_burst[i];
         burst_end <= b_burst[i];
         @(posedge clk);
         sub_end <= 1'b0;
         burst_end <= 1'b0;
         burst(1'b0, 8'h01);
         check(last, b_exp[i]);
      end
      $display("test boundaries done");
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      #1;
      check(value, 32'h0);
      check({30'h0, valid, fdone}, 32'h0);
      // release again: table and sequences start from zero
      @(posedge clk);
      rst_b <= 1'b1;
      burst(1'b1, 8'h01);
      check(last, 32'h00001000);
      $display("test second reset done");
      test_done();
   end
endmodule
